//--- ecp_top.sv
`include "ecp_params.svh"
`default_nettype none
// Summary of operation
// R1 - compare 16-bit value against selected timer
// R2 - match drives, clears, toggles or keeps pin
// R3 - match sets interrupt flag one cycle later
// R4 - clearing control register forces output latch low; in the code a match in the same cycle that sets or keeps the latch wins
// R5 - mode 1010 sets flag only
// R6 - mode 1011 makes special event pulse
// R7 - special event resets selected timer pair
// R8 - special event starts enabled converter only
// R9 - software keeps timer synchronous
// R10 - software sets pin direction to output
// R11 - restart bit clears shutdown flag automatically
// R12 - delay count postpones active-going pwm edges
// R13 - steering puts pwm on any pins
// R14 - single output mode enables steering bits
// R15 - low mode bits set pin polarity
// R16 - shutdown touches only enabled pins
// R17 - toggle inverts latch once per match
module ecp_top (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire ecp_pkg::ecp_req_t reg_req_i,
  output logic [7:0]            reg_rdata_o,
  input  wire logic [15:0]      timer_a_i,
  input  wire logic [15:0]      timer_b_i,
  output logic                  timer_a_rst_o,
  output logic                  timer_b_rst_o,
  input  wire logic             adc_enabled_i,
  output logic                  adc_start_o,
  output logic                  special_trig_o,
  input  wire logic             pwm_raw_i,
  input  wire logic             shutdown_evt_i,
  output logic                  compare_output_pin_o,
  output logic [3:0]            pwm_output_pins_o,
  output logic                  match_irq_flag_o
);
  import ecp_pkg::*;

  ecp_st_t    st_q;
  ecp_st_t    st_d;
  logic [3:0] mode_select_field;
  logic [1:0] output_config_bits;
  logic       auto_restart_enable;
  logic [6:0] delay_count_field;
  logic [15:0] timer_sel;
  logic       cmp_mode;
  logic       eq_now;
  logic       match;
  logic       steer_active;
  logic       pwm_dly;
  logic       wr_ctrl;
  logic       wr_stat;

  // field views of the stored registers
  assign mode_select_field   = st_q.ctrl[`ECP_CTRL_MODE_MSB:0];
  assign output_config_bits  = st_q.ctrl[`ECP_CTRL_CFG_LSB+1:`ECP_CTRL_CFG_LSB];
  assign auto_restart_enable = st_q.del[`ECP_DEL_RSEN_BIT];
  assign delay_count_field   = st_q.del[6:0];

  // compare match detection on the selected timer pair
  assign timer_sel = st_q.tsel ? timer_b_i : timer_a_i;              // see R1
  assign cmp_mode  = (mode_select_field == `ECP_MODE_TOGGLE)  ||
                     (mode_select_field == `ECP_MODE_SET_HI)  ||
                     (mode_select_field == `ECP_MODE_SET_LO)  ||
                     (mode_select_field == `ECP_MODE_SW_IRQ)  ||
                     (mode_select_field == `ECP_MODE_SPECIAL);
  assign eq_now    = (timer_sel == st_q.cmpv);                       // see R1
  assign match     = cmp_mode && eq_now && !st_q.eq_prev;            // see R17

  // steering is live only in single output pwm mode
  assign steer_active = (mode_select_field[3:2] == `ECP_MODE_PWM_HI) &&
                        (output_config_bits == `ECP_CFG_SINGLE);     // see R14

  // write decode
  assign wr_ctrl = reg_req_i.wr && (reg_req_i.addr == `ECP_OFS_CTRL);
  assign wr_stat = reg_req_i.wr && (reg_req_i.addr == `ECP_OFS_STATUS);

  // next state: register writes, compare actions, shutdown, read data
  always_comb begin
    st_d         = st_q;
    st_d.eq_prev = eq_now && cmp_mode;
    st_d.trig    = 1'b0;
    st_d.rst_a   = 1'b0;
    st_d.rst_b   = 1'b0;
    st_d.adc_start = 1'b0;

    // register writes
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `ECP_OFS_CTRL:   st_d.ctrl        = reg_req_i.wdata;
        `ECP_OFS_CMP_LO: st_d.cmpv[7:0]   = reg_req_i.wdata;
        `ECP_OFS_CMP_HI: st_d.cmpv[15:8]  = reg_req_i.wdata;
        `ECP_OFS_TSEL:   st_d.tsel        = reg_req_i.wdata[0];
        `ECP_OFS_DELAY:  st_d.del         = reg_req_i.wdata;
        `ECP_OFS_STEER:  st_d.steer       = reg_req_i.wdata[3:0];
        default: ;
      endcase
    end

    // software clears flags by writing zero to them
    if (wr_stat && !reg_req_i.wdata[`ECP_STAT_IRQ_BIT]) begin
      st_d.irq = 1'b0;
    end
    if (wr_stat && !reg_req_i.wdata[`ECP_STAT_SHUT_BIT]) begin
      st_d.shut = 1'b0;                                              // see R11
    end

    // clearing the control register drops the output latch unless a match in the same cycle sets or keeps it
    if (wr_ctrl && (reg_req_i.wdata == `ECP_RST_BYTE)) begin
      st_d.cmp_out = 1'b0;                                           // see R4
    end

    // compare match actions; the flag set wins over a clear
    if (match) begin
      st_d.irq = 1'b1;                                               // see R3
      unique case (mode_select_field)
        `ECP_MODE_SET_HI:  st_d.cmp_out = 1'b1;                      // see R2
        `ECP_MODE_SET_LO:  st_d.cmp_out = 1'b0;                      // see R2
        `ECP_MODE_TOGGLE:  st_d.cmp_out = ~st_q.cmp_out;             // see R2 see R17
        `ECP_MODE_SW_IRQ:  st_d.cmp_out = st_q.cmp_out;              // see R5
        `ECP_MODE_SPECIAL: begin
          st_d.trig      = 1'b1;                                     // see R6
          st_d.rst_a     = ~st_q.tsel;                               // see R7
          st_d.rst_b     = st_q.tsel;                                // see R7
          st_d.adc_start = adc_enabled_i;                            // see R8
        end
        default: ;
      endcase
    end

    // shutdown: set on the event, auto clear once it ends if enabled
    if (shutdown_evt_i) begin
      st_d.shut = 1'b1;                                              // see R16
    end else if (auto_restart_enable && st_q.shut) begin
      st_d.shut = 1'b0;                                              // see R11
    end

    // read data stands in the cycle after the read strobe
    st_d.rdata = `ECP_RST_BYTE;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `ECP_OFS_CTRL:   st_d.rdata = st_q.ctrl;
        `ECP_OFS_CMP_LO: st_d.rdata = st_q.cmpv[7:0];
        `ECP_OFS_CMP_HI: st_d.rdata = st_q.cmpv[15:8];
        `ECP_OFS_TSEL:   st_d.rdata = {7'h00, st_q.tsel};
        `ECP_OFS_DELAY:  st_d.rdata = st_q.del;
        `ECP_OFS_STEER:  st_d.rdata = {4'h0, st_q.steer};
        `ECP_OFS_STATUS: st_d.rdata = {5'h00, st_q.cmp_out, st_q.shut, st_q.irq};
        default:         st_d.rdata = `ECP_RST_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q       <= '0;
      st_q.steer <= `ECP_RST_STEER;
    end else begin
      st_q <= st_d;
    end
  end

  // dead-band delay of the raw pwm waveform
  ecp_dly u_dly (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .pwm_i     (pwm_raw_i),
    .delay_i   (delay_count_field),
    .pwm_o     (pwm_dly)
  );

  // one steered pin per output; pins a,c follow mode bit 1, b,d bit 0
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_pin
    ecp_pin u_pin (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .pwm_i     (pwm_dly),
      .en_i      (steer_active && st_q.steer[gi]),                   // see R13 see R14
      .inv_i     (mode_select_field[(gi % 2 == 0) ? 1 : 0]),         // see R15
      .shut_i    (st_q.shut),                                        // see R16
      .pin_o     (pwm_output_pins_o[gi])
    );
  end

  // outputs straight from the state register
  assign reg_rdata_o          = st_q.rdata;
  assign compare_output_pin_o = st_q.cmp_out;
  assign match_irq_flag_o     = st_q.irq;
  assign special_trig_o       = st_q.trig;
  assign timer_a_rst_o        = st_q.rst_a;
  assign timer_b_rst_o        = st_q.rst_b;
  assign adc_start_o          = st_q.adc_start;

  // named sequences for the special event chain
  sequence s_special_match;
    match && (mode_select_field == `ECP_MODE_SPECIAL);
  endsequence

  sequence s_trig_out;
    special_trig_o && (timer_a_rst_o != timer_b_rst_o);
  endsequence

  chk_match_sets_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R3
    match |=> match_irq_flag_o)
    else $error("match did not set the interrupt flag");

  chk_drive_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R2
    match && (mode_select_field == `ECP_MODE_SET_HI) |=> compare_output_pin_o && match_irq_flag_o)
    else $error("drive high match did not raise the pin");

  chk_drive_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R2
    match && (mode_select_field == `ECP_MODE_SET_LO) |=> !compare_output_pin_o)
    else $error("drive low match did not clear the pin");

  chk_toggle_once: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R17
    match && (mode_select_field == `ECP_MODE_TOGGLE) && !wr_ctrl
      |=> compare_output_pin_o != $past(compare_output_pin_o) ##1 !match || $stable(st_q.ctrl))
    else $error("toggle match did not invert the latch");

  chk_swirq_pin: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R5
    match && (mode_select_field == `ECP_MODE_SW_IRQ) && !wr_ctrl |=> $stable(compare_output_pin_o))
    else $error("software interrupt mode changed the pin");

  chk_special_trig: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R6 see R7
    s_special_match |=> s_trig_out ##1 !special_trig_o)
    else $error("special event did not pulse once with one timer reset");

  chk_timer_pick: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R7
    special_trig_o |-> timer_b_rst_o == $past(st_q.tsel))
    else $error("special event reset the wrong timer");

  chk_adc_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R8
    adc_start_o |-> special_trig_o && $past(adc_enabled_i))
    else $error("conversion started without enabled converter");

  chk_ctrl_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R4
    wr_ctrl && (reg_req_i.wdata == `ECP_RST_BYTE) && !match |=> !compare_output_pin_o)
    else $error("clearing control did not force the latch low");

  chk_auto_restart: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R11
    st_q.shut && auto_restart_enable && !shutdown_evt_i && !reg_req_i.wr |=> !st_q.shut)
    else $error("shutdown flag not cleared automatically");

  chk_shut_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R11
    st_q.shut && !auto_restart_enable && !wr_stat |=> st_q.shut)
    else $error("shutdown flag cleared without software");

  chk_steer_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R14
    !steer_active [*2] |-> pwm_output_pins_o == 4'h0)
    else $error("pins driven while steering inactive");

  // named sequences for the latch, flag and steering checks
  sequence s_quiet_pin;
    !match && !wr_ctrl;
  endsequence

  sequence s_flag_held;
    match_irq_flag_o && !wr_stat;
  endsequence

  sequence s_shut_steer;
    st_q.shut && steer_active;
  endsequence

  sequence s_run_steer;
    !st_q.shut && steer_active;
  endsequence

  // compare value against the selected timer, one match per equality run
  chk_cmp_timer_pick: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R1
    match |-> (st_q.tsel && (timer_b_i == st_q.cmpv)) || (!st_q.tsel && (timer_a_i == st_q.cmpv)))
    else $error("match without equality on the selected timer");

  chk_match_rearm: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R17
    match |=> !match)
    else $error("match repeated while the timer stayed equal");

  // latch and flag move only on their own events
  chk_pin_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R2
    s_quiet_pin |=> $stable(compare_output_pin_o))
    else $error("compare pin moved without a match");

  chk_ctrl_keep: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R4
    wr_ctrl && (reg_req_i.wdata != `ECP_RST_BYTE) && !match |=> $stable(compare_output_pin_o))
    else $error("nonzero control write disturbed the latch");

  chk_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R3
    s_flag_held |=> match_irq_flag_o)
    else $error("match flag dropped without a status write");

  chk_flag_cause: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R3
    !match_irq_flag_o && !match |=> !match_irq_flag_o)
    else $error("match flag set without a match");

  chk_swirq_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R5
    match && (mode_select_field == `ECP_MODE_SW_IRQ) |=> match_irq_flag_o && !special_trig_o)
    else $error("software interrupt mode did more than set the flag");

  // special event chain
  chk_trig_cause: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R6
    !(match && (mode_select_field == `ECP_MODE_SPECIAL)) |=> !special_trig_o)
    else $error("special event without a special mode match");

  chk_trig_single: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R6
    special_trig_o |=> !special_trig_o)
    else $error("special event pulse longer than one cycle");

  chk_rst_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R7
    !special_trig_o |-> !timer_a_rst_o && !timer_b_rst_o)
    else $error("timer reset without a special event");

  chk_adc_follow: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R8
    match && (mode_select_field == `ECP_MODE_SPECIAL) && adc_enabled_i |=> adc_start_o)
    else $error("special event did not start the enabled converter");

  chk_adc_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R8
    !adc_enabled_i |=> !adc_start_o)
    else $error("conversion started while converter disabled");

  // shutdown and steered pins
  chk_shut_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R16
    shutdown_evt_i |=> st_q.shut)
    else $error("shutdown event did not set the shutdown flag");

  chk_restart_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R11
    !st_q.shut && !shutdown_evt_i |=> !st_q.shut)
    else $error("shutdown flag set without an event");

  chk_shut_pins: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R16
    s_shut_steer |=> pwm_output_pins_o ==
                     ($past(st_q.steer) & {2{$past(mode_select_field[0]), $past(mode_select_field[1])}}))
    else $error("shutdown did not hold enabled pins at their inactive level");

  chk_steer_route: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R13
    s_run_steer |=> pwm_output_pins_o == ($past(st_q.steer) &
                    ({4{$past(pwm_dly)}} ^ {2{$past(mode_select_field[0]), $past(mode_select_field[1])}})))
    else $error("steered pins do not follow the delayed pwm");

endmodule : ecp_top
`default_nettype wire

//--- ecp_params.svh
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH

// register offsets on the plain register port
`define ECP_OFS_CTRL      3'h0
`define ECP_OFS_CMP_LO    3'h1
`define ECP_OFS_CMP_HI    3'h2
`define ECP_OFS_TSEL      3'h3
`define ECP_OFS_DELAY     3'h4
`define ECP_OFS_STEER     3'h5
`define ECP_OFS_STATUS    3'h6

// field positions
`define ECP_CTRL_MODE_MSB 3
`define ECP_CTRL_CFG_LSB  6
`define ECP_DEL_RSEN_BIT  7
`define ECP_STAT_IRQ_BIT  0
`define ECP_STAT_SHUT_BIT 1
`define ECP_STAT_CMP_BIT  2

// mode select field codes
`define ECP_MODE_OFF      4'h0
`define ECP_MODE_TOGGLE   4'h2
`define ECP_MODE_SET_HI   4'h8
`define ECP_MODE_SET_LO   4'h9
`define ECP_MODE_SW_IRQ   4'ha
`define ECP_MODE_SPECIAL  4'hb
`define ECP_MODE_PWM_HI   2'h3
`define ECP_CFG_SINGLE    2'h0

// reset values
`define ECP_RST_BYTE      8'h00
`define ECP_RST_WORD      16'h0000
`define ECP_RST_STEER     4'h1

// one delay step is one system clock (the instruction clock)
`define ECP_DLY_STEP_CYC  1

`endif

//--- ecp_pkg.sv
`default_nettype none
package ecp_pkg;

  // register port request, one cycle per access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ecp_req_t;

  // state of the dead-band delay stage
  typedef struct packed {
    logic [6:0] cnt;
    logic       out;
  } ecp_dly_st_t;

  // state of one steered output pin
  typedef struct packed {
    logic pin;
  } ecp_pin_st_t;

  // state of the main unit
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cmpv;
    logic        tsel;
    logic [7:0]  del;
    logic [3:0]  steer;
    logic        irq;
    logic        shut;
    logic        cmp_out;
    logic        eq_prev;
    logic        trig;
    logic        rst_a;
    logic        rst_b;
    logic        adc_start;
    logic [7:0]  rdata;
  } ecp_st_t;

endpackage : ecp_pkg
`default_nettype wire

//--- ecp_dly.sv
`include "ecp_params.svh"
`default_nettype none
module ecp_dly (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       pwm_i,
  input  wire logic [6:0] delay_i,
  output logic            pwm_o
);
  import ecp_pkg::*;

  ecp_dly_st_t st_q;
  ecp_dly_st_t st_d;

  // falling edges pass at once, rising edges wait delay_i steps
  always_comb begin
    st_d = st_q;
    if (!pwm_i) begin
      st_d.out = 1'b0;
      st_d.cnt = 7'h00;
    end else if (!st_q.out) begin
      if (st_q.cnt == delay_i) begin
        st_d.out = 1'b1;                                   // see R12
      end else begin
        st_d.cnt = st_q.cnt + 7'(`ECP_DLY_STEP_CYC);       // see R12
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pwm_o = st_q.out;

  chk_dly_rise_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R12
    $rose(st_q.out) |-> $past(st_q.cnt) == $past(delay_i))
    else $error("delayed pwm rose before the count elapsed");

endmodule : ecp_dly
`default_nettype wire

//--- ecp_pin.sv
`default_nettype none
module ecp_pin (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic pwm_i,
  input  wire logic en_i,
  input  wire logic inv_i,
  input  wire logic shut_i,
  output logic      pin_o
);
  import ecp_pkg::*;

  ecp_pin_st_t st_q;
  ecp_pin_st_t st_d;

  // disabled pins stay low; shutdown forces the inactive level
  always_comb begin
    st_d = st_q;
    if (en_i) begin
      st_d.pin = (pwm_i & ~shut_i) ^ inv_i;                // see R15 see R16
    end else begin
      st_d.pin = 1'b0;                                     // see R14
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_o = st_q.pin;

  chk_pin_shut_level: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R16
    en_i && shut_i |=> pin_o == $past(inv_i))
    else $error("enabled pin not at inactive level in shutdown");

endmodule : ecp_pin
`default_nettype wire

//--- ecp_timer_model.sv
`default_nettype none
module ecp_timer_model #(
  parameter int PER_A = 48,
  parameter int PER_B = 300
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        rst_a_i,
  input  wire logic        rst_b_i,
  output logic      [15:0] timer_a_o,
  output logic      [15:0] timer_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // two timers counting on the system clock, wrap at their period, cleared by the special event
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_a_o <= 16'h0000;
      timer_b_o <= 16'h0000;
    end else begin
      timer_a_o <= (rst_a_i || timer_a_o == 16'(PER_A - 1)) ? 16'h0000 : timer_a_o + 16'h0001;
      timer_b_o <= (rst_b_i || timer_b_o == 16'(PER_B - 1)) ? 16'h0000 : timer_b_o + 16'h0001;
    end
  end
endmodule : ecp_timer_model
`default_nettype wire

//--- enhanced_compare_pwm_steering_test.sv
`include "ecp_params.svh"
`default_nettype none
module enhanced_compare_pwm_steering_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ecp_pkg::*;

  logic        clk_sys_i, nrst_i, adc_en, pwm_raw, shut_evt;
  logic        rst_a, rst_b, adc_start, trig, cmp_pin, irq;
  ecp_req_t    req;
  logic [7:0]  rdata, rv;
  logic [15:0] tmr_a, tmr_b;
  logic [3:0]  pins;
  int          n_fail, num_checks, n;
  logic [3:0]  modes [6] = '{`ECP_MODE_SET_HI, `ECP_MODE_SW_IRQ, `ECP_MODE_TOGGLE,
                             `ECP_MODE_TOGGLE, `ECP_MODE_SET_LO, `ECP_MODE_SET_HI};
  logic        pexp [6]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  ecp_top u_dut (
    .clk_sys_i            (clk_sys_i),
    .nrst_i               (nrst_i),
    .reg_req_i            (req),
    .reg_rdata_o          (rdata),
    .timer_a_i            (tmr_a),
    .timer_b_i            (tmr_b),
    .timer_a_rst_o        (rst_a),
    .timer_b_rst_o        (rst_b),
    .adc_enabled_i        (adc_en),
    .adc_start_o          (adc_start),
    .special_trig_o       (trig),
    .pwm_raw_i            (pwm_raw),
    .shutdown_evt_i       (shut_evt),
    .compare_output_pin_o (cmp_pin),
    .pwm_output_pins_o    (pins),
    .match_irq_flag_o     (irq)
  );

  ecp_timer_model u_tmr (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .rst_a_i   (rst_a),
    .rst_b_i   (rst_b),
    .timer_a_o (tmr_a),
    .timer_b_o (tmr_b)
  );

  // 100 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // verdict and end of run
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // compare seen against expected
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one register access, read data taken in the cycle after the strobe
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    req <= '{w, !w, a, d};
    @(posedge clk_sys_i);
    req <= '0;
    #1 q = rdata;
  endtask : acc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d, rv);
  endtask : wr

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, rv);
    chk(16'(rv), 16'(e));
  endtask : rdc

  // bounded wait: 0 flag, 1 trigger pulse, 2 pins equal e; c counts edges
  task automatic wait_on(input int sel, input logic [3:0] e, output int c);
    for (c = 1; c < 400; c++) begin
      @(posedge clk_sys_i);
      #1;
      if ((sel == 0 && irq === 1'b1) || (sel == 1 && trig === 1'b1) || (sel == 2 && pins === e)) return;
    end
    n_fail++;
    final_report();
  endtask : wait_on

  // main sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    req = '0;
    adc_en = 1'b0;
    pwm_raw = 1'b0;
    shut_evt = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // reset values, unmapped offset 7 included
    for (int a = 0; a < 8; a++) rdc(3'(a), (a == 5) ? `ECP_RST_STEER : `ECP_RST_BYTE);
    // write then read back
    wr(`ECP_OFS_CTRL, 8'h30);
    rdc(`ECP_OFS_CTRL, 8'h30);
    wr(`ECP_OFS_DELAY, 8'hff);
    rdc(`ECP_OFS_DELAY, 8'hff);
    wr(3'h7, 8'hff);
    rdc(3'h7, 8'h00);
    wr(`ECP_OFS_CMP_HI, 8'h00);
    wr(`ECP_OFS_CMP_LO, 8'h10);
    wr(`ECP_OFS_TSEL, 8'h00);
    wr(`ECP_OFS_DELAY, 8'h00);
    // compare actions on the pin, flag set alongside
    for (int i = 0; i < 6; i++) begin
      wr(`ECP_OFS_STATUS, 8'h00);
      wr(`ECP_OFS_CTRL, {4'h0, modes[i]});
      wait_on(0, 4'h0, n);
      chk(16'(cmp_pin), 16'(pexp[i]));
      rdc(`ECP_OFS_STATUS, {5'h00, pexp[i], 2'b01});
    end
    wr(`ECP_OFS_CTRL, 8'h00);
    @(posedge clk_sys_i);
    #1 chk(16'(cmp_pin), 16'h0000);
    // special event on timer A with converter enabled, then timer B without
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_i);
      adc_en <= !k[0];
      wr(`ECP_OFS_STATUS, 8'h00);
      wr(`ECP_OFS_CMP_HI, 8'(k));
      wr(`ECP_OFS_TSEL, 8'(k));
      wr(`ECP_OFS_CTRL, {4'h0, `ECP_MODE_SPECIAL});
      wait_on(1, 4'h0, n);
      chk(16'({rst_b, rst_a, adc_start, irq}), 16'({k[0], !k[0], !k[0], 1'b1}));
      @(posedge clk_sys_i);
      #1 chk(k ? tmr_b : tmr_a, 16'h0000);
      chk(16'(trig), 16'h0000);
    end
    // steered pwm on A and C, pins taken as outputs rise delayed by the count, fall not
    wr(`ECP_OFS_CTRL, 8'h0c);
    wr(`ECP_OFS_STEER, 8'h05);
    for (int k = 0; k < 2; k++) begin
      wr(`ECP_OFS_DELAY, 8'(k * 5));
      @(posedge clk_sys_i);
      pwm_raw <= 1'b1;
      wait_on(2, 4'h5, n);
      chk(16'(n), 16'(k * 5 + 2));
      @(posedge clk_sys_i);
      pwm_raw <= 1'b0;
      wait_on(2, 4'h0, n);
      chk(16'(n), 16'h0002);
    end
    // polarity from the two low mode bits, all pins steered
    wr(`ECP_OFS_STEER, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      wr(`ECP_OFS_CTRL, 8'h0c | 8'(m));
      repeat (3) @(posedge clk_sys_i);
      #1 chk(16'(pins), 16'({m[0], m[1], m[0], m[1]}));
    end
    // an output configuration other than single output turns steering off
    wr(`ECP_OFS_CTRL, 8'h4f);
    repeat (3) @(posedge clk_sys_i);
    #1 chk(16'(pins), 16'h0000);
    // shutdown without and with automatic restart
    wr(`ECP_OFS_CTRL, 8'h0c);
    wr(`ECP_OFS_STEER, 8'h01);
    @(posedge clk_sys_i);
    pwm_raw <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(`ECP_OFS_DELAY, k ? 8'h80 : 8'h00);
      wait_on(2, 4'h1, n);
      @(posedge clk_sys_i);
      shut_evt <= 1'b1;
      wait_on(2, 4'h0, n);
      @(posedge clk_sys_i);
      shut_evt <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1 chk(16'(pins), 16'(k));
      acc(1'b0, `ECP_OFS_STATUS, 8'h00, rv);
      chk(16'(rv[`ECP_STAT_SHUT_BIT]), 16'(!k[0]));
      wr(`ECP_OFS_STATUS, 8'h00);
      wait_on(2, 4'h1, n);
    end
    final_report();
  end
endmodule : enhanced_compare_pwm_steering_test
`default_nettype wire
